//--- src/dla_pkg.sv
package dla_pkg;
  localparam int SMP_W     = 16;
  localparam int GAIN_W    = 20;
  localparam int GAIN_FRAC = 16;

  // register offsets on the control port
  localparam logic [6:0] ADDR_DAC_CTRL = 7'h0a;
  localparam logic [6:0] ADDR_LIM_ONE  = 7'h18;
  localparam logic [6:0] ADDR_LIM_TWO  = 7'h19;

  // field positions
  localparam int SILENCE_EN_POS = 2;
  localparam int LIM_EN_POS     = 8;
  localparam int DCY_POS        = 4;
  localparam int ATK_POS        = 0;
  localparam int LVL_POS        = 4;
  localparam int BOOST_POS      = 0;

  // reset values
  localparam logic       RST_ZERO_MUTE = 1'b0;
  localparam logic       RST_LIM_EN    = 1'b0;
  localparam logic [3:0] RST_RELEASE   = 4'h3;
  localparam logic [3:0] RST_ATTACK    = 4'h2;
  localparam logic [2:0] RST_LEVEL     = 3'h0;
  localparam logic [3:0] RST_LIFT      = 4'h0;

  // zero run that engages the mute
  localparam logic [10:0] ZERO_RUN_LEN = 11'h400;

  // ramp times per 6dB at the reference sample rate, code 0
  localparam longint REF_FS_HZ = 44100;
  localparam longint ATK0_NS   = 94000;
  localparam longint DCY0_NS   = 750000;
  localparam longint NS_PER_S  = 1000000000;
  localparam logic [3:0] TIME_CODE_MAX = 4'hb;
  localparam logic [2:0] LVL_CODE_MAX  = 3'h5;
  localparam logic [3:0] LIFT_CODE_MAX = 4'hc;

  // per-sample gain step: one octave (6dB) in Q16 spread over the ramp time
  localparam logic [19:0] ATK_STEP0 =
    20'(((longint'(1) << GAIN_FRAC) * NS_PER_S) / (ATK0_NS * REF_FS_HZ));
  localparam logic [19:0] DCY_STEP0 =
    20'(((longint'(1) << GAIN_FRAC) * NS_PER_S) / (DCY0_NS * REF_FS_HZ));

  // 1dB expressed in octaves, Q16
  localparam logic signed [19:0] ONE_DB     = 20'sh0_2a85;
  localparam logic signed [19:0] GAIN_FLOOR = 20'shc_0000;

  // full-scale amplitude for -0.5dB .. -6.5dB in 1dB steps
  localparam logic [15:0] THR_AMP [0:6] = '{
    16'h78d6, 16'h6bb2, 16'h5ffc, 16'h558c, 16'h4c3e, 16'h43f3, 16'h3c90};

  // 2^(i/16) in Q1.15
  localparam logic [15:0] EXP_LUT [0:15] = '{
    16'h8000, 16'h85ab, 16'h8b96, 16'h91c4, 16'h9838, 16'h9ef5, 16'ha5ff, 16'had58,
    16'hb505, 16'hbd09, 16'hc567, 16'hce25, 16'hd745, 16'he0cd, 16'heac1, 16'hf525};

  typedef enum logic [1:0] {
    DLA_HOLD   = 2'b00,
    DLA_ATTACK = 2'b01,
    DLA_DECAY  = 2'b11
  } dla_phase_t;
endpackage

//--- src/dla_gain_if.sv
`timescale 1ns/100ps
interface dla_gain_if;
  logic signed [dla_pkg::SMP_W-1:0]  sample;
  logic signed [dla_pkg::GAIN_W-1:0] gain;
  logic signed [dla_pkg::SMP_W-1:0]  result;
  modport src  (output sample, output gain, input result);
  modport unit (input sample, input gain, output result);
endinterface

//--- src/dla_gain_apply.sv
`timescale 1ns/100ps
module dla_gain_apply (
  dla_gain_if.unit g
);
  logic signed [3:0]  oct;
  logic        [3:0]  fidx;
  logic signed [32:0] prod;
  logic signed [34:0] wide;
  logic signed [34:0] shifted;
  logic        [4:0]  sh;

  // gain is log2 in Q16: integer octaves shift, top fraction bits index the table
  always_comb begin
    oct     = g.gain[19:16];
    fidx    = g.gain[15:12];
    prod    = g.sample * $signed({1'b0, dla_pkg::EXP_LUT[fidx]});
    wide    = {prod, 2'b00};
    sh      = 5'd17 - 5'({oct[3], oct});
    shifted = wide >>> sh;
    // saturate rather than wrap; boost can push peaks past full scale
    if (shifted > 35'sd32767) begin
      g.result = 16'sh7fff;
    end else if (shifted < -35'sd32768) begin
      g.result = 16'sh8000;
    end else begin
      g.result = shifted[15:0];
    end
  end
endmodule

//--- src/dla_zero_mute.sv
`timescale 1ns/100ps
module dla_zero_mute (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic valid,
  input  wire logic is_zero,
  output logic      mute_next,
  output logic      muted
);
  logic [10:0] run;
  logic [10:0] next_run;

  // run length saturates at the trigger so it never wraps back to unmuted
  always_comb begin
    next_run  = run;
    mute_next = muted;
    if (valid) begin
      if (!is_zero) begin
        next_run = 11'h000;
      end else if (run != dla_pkg::ZERO_RUN_LEN) begin
        next_run = run + 11'h001;
      end
      mute_next = enable && (next_run == dla_pkg::ZERO_RUN_LEN);
    end else if (!enable) begin
      mute_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run   <= 11'h000;
      muted <= 1'b0;
    end else begin
      run   <= next_run;
      muted <= mute_next;
    end
  end
endmodule

//--- src/dla_top.sv
`timescale 1ns/100ps
module dla_top (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [6:0]  REG_ADDR,
  input  wire logic [8:0]  REG_WDATA,
  input  wire logic        REG_WR,
  output logic      [8:0]  REG_RDATA,
  input  wire logic [15:0] SAMPLE_IN,
  input  wire logic        SAMPLE_VALID,
  output logic      [15:0] SAMPLE_OUT,
  output logic             SAMPLE_OUT_VALID,
  output logic             AUTO_MUTED,
  output logic      [1:0]  LIMIT_PHASE
);
  // control fields
  logic       zero_run_silence_enable;
  logic       peak_limiter_enable;
  logic [3:0] limiter_release_time;
  logic [3:0] limiter_attack_time;
  logic [2:0] limiter_threshold_level;
  logic [3:0] limiter_gain_lift;
  logic       next_zero_run_silence_enable;
  logic       next_peak_limiter_enable;
  logic [3:0] next_limiter_release_time;
  logic [3:0] next_limiter_attack_time;
  logic [2:0] next_limiter_threshold_level;
  logic [3:0] next_limiter_gain_lift;
  logic [8:0] next_rdata;

  // gain loop state
  // gain is a base-2 log in Q16: 65536 is one octave, about 6.02dB, and 0 is
  // unity; in the log domain every ramp is a plain add and a dB step is a
  // constant, at the price of a small table in the gain stage
  // the floor keeps a long overload from driving the gain out of range
  logic signed [19:0]  gain;
  logic signed [19:0]  next_gain;
  dla_pkg::dla_phase_t phase;
  dla_pkg::dla_phase_t next_phase;

  // output stage
  logic [15:0] next_out;
  logic        next_out_valid;

  // derived values
  // pure functions of the control fields, so a write reaches the loop
  // at the next sample with no extra latency
  logic        [3:0]  atk_code;
  logic        [3:0]  dcy_code;
  logic        [19:0] atk_step;
  logic        [19:0] dcy_step;
  logic        [2:0]  lvl_code;
  logic        [3:0]  lift_code;
  logic signed [19:0] target;
  logic        [15:0] upper_amp;
  logic        [15:0] lower_amp;
  logic        [16:0] mag;
  logic signed [15:0] applied;
  logic signed [20:0] cut;
  logic signed [20:0] rise;
  logic               mute_next;
  logic               muted;

  // the gain stage is combinational: the word leaving the output flop was
  // scaled by the gain that stood when its sample arrived
  // the new gain only applies from the following sample on
  dla_gain_if gain_bus ();

  assign gain_bus.sample = SAMPLE_IN;
  assign gain_bus.gain   = gain;
  assign applied         = gain_bus.result;

  dla_gain_apply u_gain (
    .g (gain_bus)
  );

  // zero detection looks at the raw input, ahead of any gain
  // the run counter keeps counting while automute is off, so enabling it
  // during a long silence mutes on the next zero sample rather than after
  // a fresh run of zeros
  dla_zero_mute u_mute (
    .clk       (CLK),
    .rst_b     (RST_B),
    .enable    (zero_run_silence_enable),
    .valid     (SAMPLE_VALID),
    .is_zero   (SAMPLE_IN == 16'h0000),
    .mute_next (mute_next),
    .muted     (muted)
  );

  // the flag is the mute flop itself, so it moves with the muted word
  assign AUTO_MUTED = muted;

  // register writes; unmapped offsets are ignored
  // a write takes effect at the edge that samples it; readback shows it a
  // cycle later because the read data is itself registered
  // other bits of the shared registers belong to functions outside this block
  always_comb begin
    next_zero_run_silence_enable = zero_run_silence_enable;
    next_peak_limiter_enable     = peak_limiter_enable;
    next_limiter_release_time    = limiter_release_time;
    next_limiter_attack_time     = limiter_attack_time;
    next_limiter_threshold_level = limiter_threshold_level;
    next_limiter_gain_lift       = limiter_gain_lift;
    if (REG_WR) begin
      case (REG_ADDR)
        dla_pkg::ADDR_DAC_CTRL: begin
          next_zero_run_silence_enable = REG_WDATA[dla_pkg::SILENCE_EN_POS];
        end
        dla_pkg::ADDR_LIM_ONE: begin
          next_peak_limiter_enable  = REG_WDATA[dla_pkg::LIM_EN_POS];
          next_limiter_release_time = REG_WDATA[dla_pkg::DCY_POS +: 4];
          next_limiter_attack_time  = REG_WDATA[dla_pkg::ATK_POS +: 4];
        end
        dla_pkg::ADDR_LIM_TWO: begin
          next_limiter_threshold_level = REG_WDATA[dla_pkg::LVL_POS +: 3];
          next_limiter_gain_lift       = REG_WDATA[dla_pkg::BOOST_POS +: 4];
        end
        default: begin
          next_limiter_gain_lift = limiter_gain_lift;
        end
      endcase
    end
  end

  // readback; bits belonging to other functions of these registers read zero
  // read data is registered so that the port comes straight from a flop
  always_comb begin
    next_rdata = 9'h000;
    case (REG_ADDR)
      dla_pkg::ADDR_DAC_CTRL: begin
        next_rdata[dla_pkg::SILENCE_EN_POS] = zero_run_silence_enable;
      end
      dla_pkg::ADDR_LIM_ONE: begin
        next_rdata[dla_pkg::LIM_EN_POS]  = peak_limiter_enable;
        next_rdata[dla_pkg::DCY_POS +: 4] = limiter_release_time;
        next_rdata[dla_pkg::ATK_POS +: 4] = limiter_attack_time;
      end
      dla_pkg::ADDR_LIM_TWO: begin
        next_rdata[dla_pkg::LVL_POS +: 3]   = limiter_threshold_level;
        next_rdata[dla_pkg::BOOST_POS +: 4] = limiter_gain_lift;
      end
      default: begin
        next_rdata = 9'h000;
      end
    endcase
  end

  // control field and read data flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      zero_run_silence_enable <= dla_pkg::RST_ZERO_MUTE;
      peak_limiter_enable     <= dla_pkg::RST_LIM_EN;
      limiter_release_time    <= dla_pkg::RST_RELEASE;
      limiter_attack_time     <= dla_pkg::RST_ATTACK;
      limiter_threshold_level <= dla_pkg::RST_LEVEL;
      limiter_gain_lift       <= dla_pkg::RST_LIFT;
      REG_RDATA               <= 9'h000;
    end else begin
      zero_run_silence_enable <= next_zero_run_silence_enable;
      peak_limiter_enable     <= next_peak_limiter_enable;
      limiter_release_time    <= next_limiter_release_time;
      limiter_attack_time     <= next_limiter_attack_time;
      limiter_threshold_level <= next_limiter_threshold_level;
      limiter_gain_lift       <= next_limiter_gain_lift;
      REG_RDATA               <= next_rdata;
    end
  end

  // time codes above the last table entry all take the slowest setting
  // a doubling of time is one right shift of the step, rounding down at each shift
  // steps round down, so every ramp runs slower than nominal; release code 11 rounds to a zero step and never rises
  always_comb begin
    atk_code  = (limiter_attack_time > dla_pkg::TIME_CODE_MAX) ?
                dla_pkg::TIME_CODE_MAX : limiter_attack_time;
    dcy_code  = (limiter_release_time > dla_pkg::TIME_CODE_MAX) ?
                dla_pkg::TIME_CODE_MAX : limiter_release_time;
    lvl_code  = (limiter_threshold_level > dla_pkg::LVL_CODE_MAX) ?
                dla_pkg::LVL_CODE_MAX : limiter_threshold_level;
    // reserved lift codes are held at the top step instead of overshooting
    lift_code = (limiter_gain_lift > dla_pkg::LIFT_CODE_MAX) ?
                dla_pkg::LIFT_CODE_MAX : limiter_gain_lift;
    // each code doubles the time, so it halves the per-sample step
    atk_step  = dla_pkg::ATK_STEP0 >> atk_code;
    dcy_step  = dla_pkg::DCY_STEP0 >> dcy_code;
    target    = 20'(dla_pkg::ONE_DB * $signed({1'b0, lift_code}));
    upper_amp = dla_pkg::THR_AMP[lvl_code];
    lower_amp = dla_pkg::THR_AMP[3'(lvl_code + 3'h1)];
  end

  // level of the sample as it leaves the gain stage
  // the magnitude of the most negative word needs the extra bit
  // comparing after the gain lets the loop settle on what actually leaves
  always_comb begin
    if (applied[15]) begin
      mag = 17'h0_0000 - {applied[15], applied};
    end else begin
      mag = {1'b0, applied};
    end
    cut  = {gain[19], gain} - $signed({1'b0, atk_step});
    rise = {gain[19], gain} + $signed({1'b0, dcy_step});
  end

  // with the limiter on, gain moves once per sample; between samples it holds
  // priority: above the upper threshold always cuts, even below target;
  // a lowered lift comes down next; only then may a quiet signal raise gain
  // one step per sample ties the ramp rate to the sample rate, which is
  // why the ramp times scale with it
  // with the limiter off the gain simply tracks the lift as a fixed boost
  always_comb begin
    next_gain  = gain;
    next_phase = phase;
    if (!peak_limiter_enable) begin
      next_gain  = target;
      next_phase = dla_pkg::DLA_HOLD;
    end else if (SAMPLE_VALID) begin
      case (1'b1)
        (mag > {1'b0, upper_amp}): begin
          next_phase = dla_pkg::DLA_ATTACK;
          if (cut < 21'(dla_pkg::GAIN_FLOOR)) begin
            next_gain = dla_pkg::GAIN_FLOOR;
          end else begin
            next_gain = cut[19:0];
          end
        end
        (gain > target): begin
          // lift lowered by software: come down at the attack rate
          next_phase = dla_pkg::DLA_ATTACK;
          if (cut < 21'(target)) begin
            next_gain = target;
          end else begin
            next_gain = cut[19:0];
          end
        end
        (mag < {1'b0, lower_amp} && gain < target): begin
          next_phase = dla_pkg::DLA_DECAY;
          if (rise > 21'(target)) begin
            next_gain = target;
          end else begin
            next_gain = rise[19:0];
          end
        end
        default: begin
          // between thresholds, or quiet and already at target with any lift: unchanged
          next_phase = dla_pkg::DLA_HOLD;
        end
      endcase
    end
  end

  // gain and phase flops; gain restarts at unity
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      gain  <= 20'sh0_0000;
      phase <= dla_pkg::DLA_HOLD;
    end else begin
      gain  <= next_gain;
      phase <= next_phase;
    end
  end

  // phase is a flop; hold is also reported while the limiter is off
  assign LIMIT_PHASE = phase;

  // output register; the mute decision for this very sample is used so
  // that a non-zero sample is never swallowed by a stale mute
  // between samples the last word is held, so a slow reader sees it steady
  always_comb begin
    next_out_valid = SAMPLE_VALID;
    next_out       = SAMPLE_OUT;
    if (SAMPLE_VALID) begin
      if (mute_next) begin
        next_out = 16'h0000;
      end else begin
        next_out = applied;
      end
    end
  end

  // output word and its strobe
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SAMPLE_OUT       <= 16'h0000;
      SAMPLE_OUT_VALID <= 1'b0;
    end else begin
      SAMPLE_OUT       <= next_out;
      SAMPLE_OUT_VALID <= next_out_valid;
    end
  end
endmodule

//--- tb/dla_top_monitor.sv
`timescale 1ns/100ps
module dla_top_monitor (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic [6:0]  REG_ADDR,
  input wire logic [8:0]  REG_WDATA,
  input wire logic        REG_WR,
  input wire logic [8:0]  REG_RDATA,
  input wire logic [15:0] SAMPLE_IN,
  input wire logic        SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_OUT,
  input wire logic        SAMPLE_OUT_VALID,
  input wire logic        AUTO_MUTED,
  input wire logic [1:0]  LIMIT_PHASE
);
  logic       lim_on;
  logic [3:0] lift;
  logic       next_lim_on;
  logic [3:0] next_lift;

  // shadow of enable and lift, taken from the write strobe like the block does
  always_comb begin
    next_lim_on = lim_on;
    next_lift = lift;
    if (REG_WR && REG_ADDR == dla_pkg::ADDR_LIM_ONE)
      next_lim_on = REG_WDATA[dla_pkg::LIM_EN_POS];
    if (REG_WR && REG_ADDR == dla_pkg::ADDR_LIM_TWO)
      next_lift = REG_WDATA[dla_pkg::BOOST_POS +: 4];
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lim_on <= 1'b0;
      lift <= 4'h0;
    end else begin
      lim_on <= next_lim_on;
      lift <= next_lift;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // one output word for each input word, never more
  out_valid_a: assert property (SAMPLE_VALID |=> SAMPLE_OUT_VALID)
    else $error("no output after sample");
  no_spur_a: assert property (!SAMPLE_VALID |=> !SAMPLE_OUT_VALID)
    else $error("output without sample");
  mute_zero_a: assert property (SAMPLE_OUT_VALID && AUTO_MUTED |-> SAMPLE_OUT == 16'h0000)
    else $error("muted output not zero");
  mute_cause_a: assert property ($rose(AUTO_MUTED) |->
    $past(SAMPLE_VALID) && $past(SAMPLE_IN) == 16'h0000)
    else $error("mute rose without zero sample");
  unmute_now_a: assert property (SAMPLE_VALID && SAMPLE_IN != 16'h0000 |=> !AUTO_MUTED)
    else $error("mute held after non-zero");
  phase_code_a: assert property (LIMIT_PHASE != 2'b10)
    else $error("illegal phase code");
  off_hold_a: assert property (SAMPLE_VALID && !lim_on |=>
    LIMIT_PHASE == dla_pkg::DLA_HOLD)
    else $error("phase moved with limiter off");
  unity_gain_a: assert property (SAMPLE_VALID && !lim_on && lift == 4'h0 |=>
    AUTO_MUTED || SAMPLE_OUT == $past(SAMPLE_IN))
    else $error("gain applied at zero lift");
  ctrl_bits_a: assert property ($past(REG_ADDR) == dla_pkg::ADDR_DAC_CTRL |->
    REG_RDATA[8:3] == 6'h00 && REG_RDATA[1:0] == 2'h0)
    else $error("stray bits in dac control");
endmodule

bind dla_top dla_top_monitor u_dla_top_monitor (
  .CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .SAMPLE_IN(SAMPLE_IN),
  .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_OUT(SAMPLE_OUT),
  .SAMPLE_OUT_VALID(SAMPLE_OUT_VALID), .AUTO_MUTED(AUTO_MUTED),
  .LIMIT_PHASE(LIMIT_PHASE));

//--- tb/dla_src_model.sv
`timescale 1ns/100ps
module dla_src_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [15:0] data,
  output logic      [15:0] sample,
  output logic             valid
);
  initial begin
    sample = 16'h0000;
    valid = 1'b0;
  end
  // idle word flips every cycle so a stale sample never reads as held data
  always @(posedge clk) begin
    valid <= req;
    sample <= req ? data : ~sample;
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        CLK;
  logic        RST_B;
  logic [6:0]  REG_ADDR;
  logic [8:0]  REG_WDATA;
  logic        REG_WR;
  logic [8:0]  REG_RDATA;
  logic [15:0] SAMPLE_IN;
  logic        SAMPLE_VALID;
  logic [15:0] SAMPLE_OUT;
  logic        SAMPLE_OUT_VALID;
  logic        AUTO_MUTED;
  logic [1:0]  LIMIT_PHASE;
  logic        req;
  logic [15:0] data;
  logic [15:0] got;
  int          compares;
  int          miscompares;

  dla_top u_dla_top (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
    .SAMPLE_IN(SAMPLE_IN), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_OUT(SAMPLE_OUT),
    .SAMPLE_OUT_VALID(SAMPLE_OUT_VALID), .AUTO_MUTED(AUTO_MUTED),
    .LIMIT_PHASE(LIMIT_PHASE));
  dla_src_model u_dla_src_model (.clk(CLK), .req(req), .data(data),
    .sample(SAMPLE_IN), .valid(SAMPLE_VALID));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task end_sim;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // gain steps are quantised, so level checks allow a few percent
  task automatic near(input logic [15:0] g, input real e);
    compares++;
    if ($isunknown(g) || g < e * 0.95 || g > e * 1.05) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, $rtoi(e));
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    repeat (2) @(posedge CLK);
    #1 chk(16'(REG_RDATA), 16'(e));
  endtask

  task automatic send(input logic [15:0] x);
    int i;
    @(posedge CLK);
    req <= 1'b1;
    data <= x;
    @(posedge CLK);
    req <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge CLK);
      #1;
      if (SAMPLE_OUT_VALID === 1'b1) break;
    end
    got = SAMPLE_OUT;
    if (i == 8) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, SAMPLE_OUT_VALID, 1'b1);
      end_sim;
    end
  endtask

  // back-to-back words, one per cycle
  task automatic burst(input logic [15:0] x, input int n);
    @(posedge CLK);
    req <= 1'b1;
    data <= x;
    repeat (n) @(posedge CLK);
    req <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask

  task automatic t_regs;
    rd(7'h0a, 9'h000);
    rd(7'h18, 9'h032);
    rd(7'h19, 9'h000);
    wr(7'h18, 9'h1f3);
    rd(7'h18, 9'h1f3);
    wr(7'h19, 9'h0fc);
    rd(7'h19, 9'h07c);
    wr(7'h0a, 9'h1ff);
    rd(7'h0a, 9'h004);
    wr(7'h11, 9'h1ff);
    rd(7'h11, 9'h000);
    wr(7'h0a, 9'h000);
    wr(7'h18, 9'h000);
    wr(7'h19, 9'h000);
  endtask

  task automatic t_lift;
    int n;
    for (n = 0; n < 13; n++) begin
      wr(7'h19, 9'(n));
      send(16'h03e8);
      near(got, 1000.0 * $pow(10.0, n / 20.0));
    end
    wr(7'h19, 9'h000);
    send(16'h03e8);
    chk(got, 16'h03e8);
  endtask

  task automatic t_mute;
    burst(16'h0000, 1100);
    chk(16'(AUTO_MUTED), 16'h0000);
    wr(7'h0a, 9'h004);
    send(16'h0100);
    burst(16'h0000, 1023);
    chk(16'(AUTO_MUTED), 16'h0000);
    send(16'h0000);
    chk(16'(AUTO_MUTED), 16'h0001);
    send(16'h0123);
    chk(16'(AUTO_MUTED), 16'h0000);
    chk(got, 16'h0123);
    wr(7'h0a, 9'h000);
  endtask

  task automatic t_thr;
    int c;
    real amp;
    logic [15:0] x;
    logic [15:0] y;
    wr(7'h18, 9'h100);
    for (c = 0; c < 8; c++) begin
      wr(7'h19, 9'(c << 4));
      amp = 32767.0 * $pow(10.0, -((c > 5 ? 5 : c) + 0.5) / 20.0);
      burst(16'h1000, 80);
      x = 16'($rtoi(amp * 0.98));
      send(x);
      chk(got, x);
      chk(16'(LIMIT_PHASE), 16'h0000);
      y = 16'($rtoi(amp * 1.02));
      send(y);
      chk(16'(LIMIT_PHASE), 16'h0001);
      send(y);
      near(got, y * $pow(0.5, 1.0 / (94.0e-6 * 44100.0)));
      send(16'h1000);
      chk(16'(LIMIT_PHASE), 16'h0003);
    end
    wr(7'h18, 9'h000);
  endtask

  initial begin
    RST_B = 1'b0;
    REG_ADDR = 7'h00;
    REG_WDATA = 9'h000;
    REG_WR = 1'b0;
    req = 1'b0;
    data = 16'h0000;
    compares = 0;
    miscompares = 0;
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    t_regs;
    t_lift;
    t_mute;
    t_thr;
    end_sim;
  end
endmodule
